// *** core/mmc_meas_ctrl.sv ***
// Measurement control: the two control registers, rate pacing, sensor reset and the measurement sequence.
`default_nettype none

module mmc_meas_ctrl #(
    parameter int TICK_CYCLES = mmc_pkg::TICK_CYCLES,
    parameter int SENSOR_RST_CYCLES = mmc_pkg::SENSOR_RST_CYCLES
) (
    // Clock and reset.
    input wire logic i_clk_sys,
    input wire logic i_srst,
    // Register port from the serial slave engine.
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic [7:0] o_next_addr,
    // Analog front end.
    output logic o_sample_req,
    input wire logic i_sample_valid,
    input wire mmc_pkg::mmc_triple_t i_sample,
    output logic o_sensor_reset,
    // User offsets and stored result.
    input wire mmc_pkg::mmc_triple_t i_user_offset,
    output mmc_pkg::mmc_triple_t o_result,
    output logic o_result_valid,
    // Status.
    output logic [1:0] o_operating_state,
    output logic o_busy
);

    localparam int SRST_W = $clog2(SENSOR_RST_CYCLES + 1);

    logic [7:0] ctrl1_reg;
    logic [7:0] ctrl2_reg;
    mmc_pkg::mmc_state_t state_reg;
    logic [13:0] tick_cnt_reg;
    logic tick_en;
    logic [3:0] div_cnt_reg;
    logic [14:0] per_cnt_reg;
    logic [7:0] sample_cnt_reg;
    logic [SRST_W-1:0] srst_cnt_reg;
    logic meas_pend_reg;
    logic per_pend_reg;
    logic trig_fast_reg;
    logic sample_en;
    logic period_start;
    logic start_meas;
    logic finish;
    logic srst_done;
    logic wr_c1;
    logic wr_c2;

    logic [2:0] dr;
    logic [2:0] osr_log2;
    logic [7:0] oversample_ratio;
    logic [2:0] slow_shift;
    logic [3:0] div_mask;
    logic [14:0] period_last;
    logic run;
    logic raw;

    assign dr = ctrl1_reg[mmc_pkg::C1_DR_HI:mmc_pkg::C1_DR_LO];
    assign osr_log2 = 3'(mmc_pkg::OSR_LOG2_MIN + ctrl1_reg[mmc_pkg::C1_OS_HI:mmc_pkg::C1_OS_LO]);
    assign oversample_ratio = 8'(1 << osr_log2);
    assign run = ctrl1_reg[mmc_pkg::C1_AC];
    assign raw = ctrl2_reg[mmc_pkg::C2_RAW];
    assign wr_c1 = i_reg_wr && i_reg_addr == mmc_pkg::ADDR_CTRL1;
    assign wr_c2 = i_reg_wr && i_reg_addr == mmc_pkg::ADDR_CTRL2;

    // Fields are taken whole; the host only changes pace fields while in standby.
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            ctrl1_reg <= mmc_pkg::CTRL1_RST;
        end else if (wr_c1) begin
            ctrl1_reg <= i_reg_wdata;
        end else if (finish) begin
            ctrl1_reg[mmc_pkg::C1_TM] <= 1'b0;
        end
    end

    // A host write of the reset request wins over its self-clear in the same cycle.
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            ctrl2_reg <= mmc_pkg::CTRL2_RST;
        end else if (wr_c2) begin
            ctrl2_reg <= i_reg_wdata & mmc_pkg::CTRL2_MASK;
        end else if (srst_done) begin
            ctrl2_reg[mmc_pkg::C2_RST] <= 1'b0;
        end
    end

    always_comb begin
        unique case (i_reg_addr)
            mmc_pkg::ADDR_CTRL1: o_reg_rdata = ctrl1_reg;
            mmc_pkg::ADDR_CTRL2: o_reg_rdata = ctrl2_reg;
            mmc_pkg::ADDR_OPSTATE: o_reg_rdata = {6'h00, o_operating_state};
            default: o_reg_rdata = 8'h00;
        endcase
    end

    // Burst address step; a directly addressed low byte stays readable.
    always_comb begin
        o_next_addr = 8'(i_reg_addr + 8'h01);
        if (ctrl1_reg[mmc_pkg::C1_FR] && (o_next_addr == mmc_pkg::ADDR_X_LSB
                || o_next_addr == mmc_pkg::ADDR_Y_LSB || o_next_addr == mmc_pkg::ADDR_Z_LSB)) begin
            o_next_addr = 8'(i_reg_addr + 8'h02);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_operating_state <= mmc_pkg::OPST_STANDBY;
        end else if (!run) begin
            o_operating_state <= mmc_pkg::OPST_STANDBY;
        end else begin
            o_operating_state <= raw ? mmc_pkg::OPST_RAW : mmc_pkg::OPST_CORR;
        end
    end

    // Base tick at the fastest sample rate.
    always_ff @(posedge i_clk_sys) begin
        if (i_srst || tick_en) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= 14'(tick_cnt_reg + 14'h0001);
        end
    end
    assign tick_en = tick_cnt_reg == 14'(TICK_CYCLES - 1);

    // Sample pace halves per rate code until the slowest sample rate.
    assign slow_shift = dr < mmc_pkg::SLOW_DR ? dr : mmc_pkg::SLOW_DR;
    assign div_mask = 4'((5'h01 << slow_shift) - 5'h01);
    assign sample_en = tick_en && (trig_fast_reg || (div_cnt_reg & div_mask) == 4'h0);

    always_ff @(posedge i_clk_sys) begin
        if (i_srst || state_reg != mmc_pkg::ST_COLLECT) begin
            div_cnt_reg <= '0;
        end else if (tick_en) begin
            div_cnt_reg <= 4'(div_cnt_reg + 4'h1);
        end
    end

    // Output period is the ratio times the rate divisor in base ticks.
    assign period_last = 15'((16'h0001 << (4'(osr_log2) + 4'(dr))) - 16'h0001);
    assign period_start = run && tick_en && per_cnt_reg == period_last;

    always_ff @(posedge i_clk_sys) begin
        if (i_srst || !run || period_start) begin
            per_cnt_reg <= '0;
        end else if (tick_en) begin
            per_cnt_reg <= 15'(per_cnt_reg + 15'h0001);
        end
    end

    // A period start that lands while busy waits for idle, so back-to-back measurements keep the output rate.
    always_ff @(posedge i_clk_sys) begin
        if (i_srst || !run || state_reg == mmc_pkg::ST_IDLE) begin
            per_pend_reg <= 1'b0;
        end else if (period_start) begin
            per_pend_reg <= 1'b1;
        end
    end

    assign start_meas = state_reg == mmc_pkg::ST_IDLE
        && (period_start || per_pend_reg || ctrl1_reg[mmc_pkg::C1_TM]);
    assign srst_done = state_reg == mmc_pkg::ST_SRST && srst_cnt_reg == SRST_W'(SENSOR_RST_CYCLES - 1);
    assign finish = state_reg == mmc_pkg::ST_FINISH;

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            state_reg <= mmc_pkg::ST_IDLE;
        end else begin
            unique case (state_reg)
                mmc_pkg::ST_IDLE: begin
                    if (start_meas && ctrl2_reg[mmc_pkg::C2_AUTO]) begin
                        state_reg <= mmc_pkg::ST_SRST;
                    end else if (start_meas) begin
                        state_reg <= mmc_pkg::ST_COLLECT;
                    end else if (ctrl2_reg[mmc_pkg::C2_RST]) begin
                        state_reg <= mmc_pkg::ST_SRST;
                    end
                end
                mmc_pkg::ST_SRST: begin
                    if (srst_done) begin
                        state_reg <= meas_pend_reg ? mmc_pkg::ST_COLLECT : mmc_pkg::ST_IDLE;
                    end
                end
                mmc_pkg::ST_COLLECT: begin
                    if (i_sample_valid && sample_cnt_reg == 8'(oversample_ratio - 8'h01)) begin
                        state_reg <= mmc_pkg::ST_FINISH;
                    end
                end
                mmc_pkg::ST_FINISH: begin
                    state_reg <= mmc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst || state_reg == mmc_pkg::ST_IDLE) begin
            meas_pend_reg <= start_meas;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst || state_reg != mmc_pkg::ST_SRST) begin
            srst_cnt_reg <= '0;
        end else begin
            srst_cnt_reg <= SRST_W'(srst_cnt_reg + 1'b1);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst || state_reg == mmc_pkg::ST_IDLE) begin
            sample_cnt_reg <= '0;
        end else if (state_reg == mmc_pkg::ST_COLLECT && i_sample_valid) begin
            sample_cnt_reg <= 8'(sample_cnt_reg + 8'h01);
        end
    end

    // A trigger during an active measurement in continuous mode switches it to the base pace.
    always_ff @(posedge i_clk_sys) begin
        if (i_srst || state_reg == mmc_pkg::ST_IDLE) begin
            trig_fast_reg <= 1'b0;
        end else if (run && ctrl1_reg[mmc_pkg::C1_TM]) begin
            trig_fast_reg <= 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_sample_req <= 1'b0;
        end else begin
            o_sample_req <= state_reg == mmc_pkg::ST_COLLECT && sample_en;
        end
    end

    assign o_sensor_reset = state_reg == mmc_pkg::ST_SRST;
    assign o_busy = state_reg != mmc_pkg::ST_IDLE;

    mmc_average u_average (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .i_clear(state_reg == mmc_pkg::ST_IDLE),
        .i_accum(state_reg == mmc_pkg::ST_COLLECT && i_sample_valid),
        .i_finish(finish),
        .i_shift(osr_log2),
        .i_raw(raw),
        .i_sample(i_sample),
        .i_offset(i_user_offset),
        .o_result(o_result),
        .o_result_valid(o_result_valid)
    );

    a_reset_default: assert property (@(posedge i_clk_sys)
        i_srst |=> ctrl1_reg == mmc_pkg::CTRL1_RST && state_reg == mmc_pkg::ST_IDLE)
        else $error("control one not cleared by reset");

    a_osr_complete: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        finish |-> $past(sample_cnt_reg) == 8'(oversample_ratio - 8'h01))
        else $error("measurement ended with wrong sample count");

    a_trigger_starts: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        state_reg == mmc_pkg::ST_IDLE && ctrl1_reg[mmc_pkg::C1_TM] |=> state_reg != mmc_pkg::ST_IDLE)
        else $error("trigger did not start a measurement");

    a_auto_reset: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        start_meas && ctrl2_reg[mmc_pkg::C2_AUTO] |=> state_reg == mmc_pkg::ST_SRST)
        else $error("auto sensor reset skipped");

    a_oneshot_done: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        finish && !wr_c1 |=> !ctrl1_reg[mmc_pkg::C1_TM] && state_reg == mmc_pkg::ST_IDLE)
        else $error("trigger not cleared after measurement");

    a_fast_pace: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        trig_fast_reg && tick_en && state_reg == mmc_pkg::ST_COLLECT |=> o_sample_req)
        else $error("triggered measurement not at base pace");

    a_state_field: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        $stable(ctrl1_reg) && $stable(ctrl2_reg) && !run |=> o_operating_state == mmc_pkg::OPST_STANDBY)
        else $error("operating state wrong in standby");

    a_rst_selfclear: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        srst_done && !wr_c2 |=> !ctrl2_reg[mmc_pkg::C2_RST] ##1 !o_sensor_reset || meas_pend_reg)
        else $error("sensor reset request not cleared");

    a_fast_skip: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        ctrl1_reg[mmc_pkg::C1_FR] && i_reg_addr == mmc_pkg::ADDR_X_MSB |-> o_next_addr == mmc_pkg::ADDR_Y_MSB)
        else $error("fast read did not skip low byte");

    a_period_kept: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        per_pend_reg && run && state_reg == mmc_pkg::ST_IDLE |=> state_reg != mmc_pkg::ST_IDLE)
        else $error("queued period start was lost");

    c_period_queued: cover property (@(posedge i_clk_sys) disable iff (i_srst) per_pend_reg && start_meas);

    c_periodic: cover property (@(posedge i_clk_sys) disable iff (i_srst) period_start && start_meas);
    c_oneshot: cover property (@(posedge i_clk_sys) disable iff (i_srst) finish && !run);
    c_trig_active: cover property (@(posedge i_clk_sys) disable iff (i_srst) trig_fast_reg && finish);

endmodule : mmc_meas_ctrl

`default_nettype wire

// *** core/mmc_pkg.sv ***
// Package holding the register map, field layout, timing constants and types of the measurement control block.
`default_nettype none

package mmc_pkg;

    // Register addresses.
    localparam logic [7:0] ADDR_X_MSB = 8'h01;
    localparam logic [7:0] ADDR_X_LSB = 8'h02;
    localparam logic [7:0] ADDR_Y_MSB = 8'h03;
    localparam logic [7:0] ADDR_Y_LSB = 8'h04;
    localparam logic [7:0] ADDR_Z_MSB = 8'h05;
    localparam logic [7:0] ADDR_Z_LSB = 8'h06;
    localparam logic [7:0] ADDR_OPSTATE = 8'h08;
    localparam logic [7:0] ADDR_CTRL1 = 8'h10;
    localparam logic [7:0] ADDR_CTRL2 = 8'h11;

    // Field positions of measurement_control_one.
    localparam int C1_DR_HI = 7;
    localparam int C1_DR_LO = 5;
    localparam int C1_OS_HI = 4;
    localparam int C1_OS_LO = 3;
    localparam int C1_FR = 2;
    localparam int C1_TM = 1;
    localparam int C1_AC = 0;

    // Field positions of measurement_control_two.
    localparam int C2_AUTO = 7;
    localparam int C2_RAW = 5;
    localparam int C2_RST = 4;

    // Values after reset and the writable bits of measurement_control_two.
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] CTRL2_RST = 8'h00;
    localparam logic [7:0] CTRL2_MASK = 8'hB0;

    // Operating state codes.
    localparam logic [1:0] OPST_STANDBY = 2'h0;
    localparam logic [1:0] OPST_RAW = 2'h1;
    localparam logic [1:0] OPST_CORR = 2'h2;

    // Timing: base sample rate tick and sensor reset pulse.
    localparam int CLK_HZ = 20000000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int BASE_RATE_HZ = 1280;
    localparam int TICK_CYCLES = CLK_HZ / BASE_RATE_HZ;
    localparam logic [2:0] SLOW_DR = 3'h4;
    localparam logic [2:0] OSR_LOG2_MIN = 3'h4;
    localparam int SENSOR_RST_NS = 1000;
    localparam int SENSOR_RST_CYCLES = (SENSOR_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Three axis values travelling together.
    typedef struct packed {
        logic [2:0][15:0] axis;
    } mmc_triple_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SRST,
        ST_COLLECT,
        ST_FINISH
    } mmc_state_t;

endpackage : mmc_pkg

`default_nettype wire

// *** core/mmc_average.sv ***
// Per-axis accumulator that averages the oversampled readings and applies the user offsets with bit 0 cleared.
`default_nettype none

module mmc_average #(
    parameter int ACC_W = 23
) (
    // Clock and reset.
    input wire logic i_clk_sys,
    input wire logic i_srst,
    // Control.
    input wire logic i_clear,
    input wire logic i_accum,
    input wire logic i_finish,
    input wire logic [2:0] i_shift,
    input wire logic i_raw,
    // Data.
    input wire mmc_pkg::mmc_triple_t i_sample,
    input wire mmc_pkg::mmc_triple_t i_offset,
    output mmc_pkg::mmc_triple_t o_result,
    output logic o_result_valid
);

    logic [2:0][ACC_W-1:0] acc_reg;
    logic [2:0][15:0] avg;

    for (genvar a = 0; a < 3; a++) begin : g_axis
        logic [ACC_W-1:0] shifted;
        logic [15:0] offset_even;
        assign shifted = $signed(acc_reg[a]) >>> i_shift;
        assign offset_even = {i_offset.axis[a][15:1], 1'b0};
        assign avg[a] = i_raw ? shifted[15:0] : 16'(shifted[15:0] - offset_even);

        always_ff @(posedge i_clk_sys) begin
            if (i_srst || i_clear) begin
                acc_reg[a] <= '0;
            end else if (i_accum) begin
                acc_reg[a] <= ACC_W'(acc_reg[a] + {{(ACC_W-16){i_sample.axis[a][15]}}, i_sample.axis[a]});
            end
        end

        always_ff @(posedge i_clk_sys) begin
            if (i_srst) begin
                o_result.axis[a] <= '0;
            end else if (i_finish) begin
                o_result.axis[a] <= avg[a];
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_result_valid <= 1'b0;
        end else begin
            o_result_valid <= i_finish;
        end
    end

    a_raw_passes: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        i_finish && i_raw |=> o_result.axis[0] == $past(avg[0]) && o_result_valid)
        else $error("raw result not stored as averaged");

endmodule : mmc_average

`default_nettype wire

// *** sim/mmc_frontend_model.sv ***
// Behavioural front end that answers each sample request after a chosen delay.
`default_nettype none

module mmc_frontend_model (
    // Clock and reset.
    input wire logic i_clk_sys,
    input wire logic i_srst,
    // Request side.
    input wire logic i_sample_req,
    input wire logic [3:0] i_delay,
    input wire mmc_pkg::mmc_triple_t i_value,
    // Answer side.
    output logic o_sample_valid,
    output mmc_pkg::mmc_triple_t o_sample
);
    timeunit 1ns;
    timeprecision 1ns;

    logic pending_reg;
    logic [3:0] wait_reg;

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            pending_reg <= 1'b0;
            wait_reg <= 4'h0;
            o_sample_valid <= 1'b0;
        end else begin
            o_sample_valid <= 1'b0;
            if (i_sample_req) begin
                pending_reg <= 1'b1;
                wait_reg <= i_delay;
            end else if (pending_reg) begin
                if (wait_reg == 4'h0) begin
                    pending_reg <= 1'b0;
                    o_sample_valid <= 1'b1;
                end else begin
                    wait_reg <= wait_reg - 4'h1;
                end
            end
        end
    end

    // Outside the valid pulse the data lines show the inverse so stale values cannot pass.
    assign o_sample = o_sample_valid ? i_value : ~i_value;

endmodule : mmc_frontend_model

`default_nettype wire

// *** sim/mmc_meas_ctrl_tb_top.sv ***
// Self-checking testbench of the measurement control block.
`default_nettype none

module mmc_meas_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int TICK = 8;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic wr = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [3:0] delay = 4'h0;
    logic [7:0] rdata;
    logic [7:0] next_addr;
    logic req, svalid, rst_out, rvalid, busy;
    logic [1:0] opst;
    mmc_pkg::mmc_triple_t sample, result;
    mmc_pkg::mmc_triple_t value = {16'h1234, 16'hff00, 16'h0100};
    mmc_pkg::mmc_triple_t offset = {16'hfffe, 16'h0002, 16'h0011};
    logic [47:0] corr = {16'h1236, 16'hfefe, 16'h00f0};
    int failures = 0;
    int n_checks = 0;
    int cyc = 0, nreq = 0, req_gap = 0, last_req = 0, nrst = 0, res_gap = 0, last_res = 0, base = 0;

    always #25 clk = ~clk;

    mmc_meas_ctrl #(.TICK_CYCLES(TICK), .SENSOR_RST_CYCLES(2)) u_dut (
        .i_clk_sys(clk), .i_srst(srst), .i_reg_wr(wr), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .o_next_addr(next_addr), .o_sample_req(req), .i_sample_valid(svalid),
        .i_sample(sample), .o_sensor_reset(rst_out), .i_user_offset(offset), .o_result(result),
        .o_result_valid(rvalid), .o_operating_state(opst), .o_busy(busy));

    mmc_frontend_model u_fe (.i_clk_sys(clk), .i_srst(srst), .i_sample_req(req), .i_delay(delay),
        .i_value(value), .o_sample_valid(svalid), .o_sample(sample));

    // Counts and spacings of the block's pulses, sampled where they are settled.
    always @(negedge clk) begin
        cyc++;
        if (req === 1'b1) begin
            nreq++;
            req_gap = cyc - last_req;
            last_req = cyc;
        end
        if (rst_out === 1'b1) nrst++;
        if (rvalid === 1'b1) begin
            res_gap = cyc - last_res;
            last_res = cyc;
        end
    end

    task chk_val(input logic [47:0] got, input logic [47:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk_val

    task chk_cnt(input int got, input int exp);
        n_checks++;
        if (got != exp) begin
            failures++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk_cnt

    task reg_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
    endtask : reg_write

    task reg_read(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        #1;
        chk_val({40'h0, rdata}, {40'h0, exp});
    endtask : reg_read

    task automatic wait_high(ref logic s);
        int i = 0;
        @(negedge clk);
        while (s !== 1'b1 && i < 30000) begin
            @(negedge clk);
            i++;
        end
        #1;
        chk_val({47'h0, s}, 48'h1);
    endtask : wait_high

    task stop_test;
        $display("Checks %0d, mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test

    initial begin
        repeat (95000) @(posedge clk);
        failures++;
        stop_test;
    end

    initial begin
        repeat (20) @(negedge clk);
        srst = 1'b0;
        reg_read(mmc_pkg::ADDR_CTRL1, 8'h00);
        reg_read(mmc_pkg::ADDR_CTRL2, 8'h00);
        reg_read(mmc_pkg::ADDR_OPSTATE, 8'h00);
        reg_write(mmc_pkg::ADDR_CTRL1, 8'hfc);
        reg_write(8'h20, 8'hff);
        reg_read(mmc_pkg::ADDR_CTRL1, 8'hfc);
        reg_read(8'h20, 8'h00);
        // Burst stepping with fast read set, then clear.
        for (int f = 1; f >= 0; f--) begin
            for (int a = 1; a < 7; a++) begin
                @(negedge clk);
                addr = 8'(a);
                #1;
                chk_val({40'h0, next_addr}, 48'((f == 1 && a % 2 == 1) ? a + 2 : a + 1));
            end
            reg_write(mmc_pkg::ADDR_CTRL1, 8'h00);
        end
        reg_write(mmc_pkg::ADDR_CTRL2, 8'hef);
        reg_read(mmc_pkg::ADDR_CTRL2, 8'ha0);
        reg_write(mmc_pkg::ADDR_CTRL2, 8'h00);
        base = nrst;
        reg_write(mmc_pkg::ADDR_CTRL2, 8'h10);
        repeat (6) @(negedge clk);
        #1;
        chk_cnt(nrst - base, 2);
        reg_read(mmc_pkg::ADDR_CTRL2, 8'h00);
        // One-shot in standby at every oversample code.
        for (int os = 0; os < 4; os++) begin
            base = nreq;
            reg_write(mmc_pkg::ADDR_CTRL1, {3'h0, 2'(os), 3'h2});
            wait_high(rvalid);
            chk_cnt(nreq - base, 16 << os);
            chk_val(result, corr);
            repeat (2) @(negedge clk);
            chk_val({47'h0, busy}, 48'h0);
            reg_read(mmc_pkg::ADDR_CTRL1, {3'h0, 2'(os), 3'h0});
            reg_read(mmc_pkg::ADDR_OPSTATE, 8'h00);
        end
        reg_write(mmc_pkg::ADDR_CTRL2, 8'ha0);
        base = nrst;
        reg_write(mmc_pkg::ADDR_CTRL1, 8'h02);
        wait_high(rvalid);
        chk_cnt(nrst - base, 2);
        chk_val(result, value);
        // Periodic measurements at every rate code, with a slower front end.
        reg_write(mmc_pkg::ADDR_CTRL2, 8'h20);
        delay = 4'h1;
        for (int dr = 0; dr < 8; dr++) begin
            reg_write(mmc_pkg::ADDR_CTRL1, 8'h00);
            repeat (300) @(negedge clk);
            reg_write(mmc_pkg::ADDR_CTRL1, {3'(dr), 5'h01});
            wait_high(rvalid);
            wait_high(rvalid);
            chk_cnt(res_gap, (16 << dr) * TICK);
            chk_cnt(req_gap, (1 << (dr > 4 ? 4 : dr)) * TICK);
            chk_val({46'h0, opst}, 48'h1);
        end
        reg_write(mmc_pkg::ADDR_CTRL1, 8'h00);
        reg_write(mmc_pkg::ADDR_CTRL2, 8'h00);
        reg_write(mmc_pkg::ADDR_CTRL1, 8'h81);
        repeat (4) @(negedge clk);
        reg_read(mmc_pkg::ADDR_OPSTATE, 8'h02);
        wait_high(busy);
        reg_write(mmc_pkg::ADDR_CTRL1, 8'h83);
        repeat (3 * TICK) @(negedge clk);
        #1;
        chk_cnt(req_gap, TICK);
        wait_high(rvalid);
        chk_val(result, corr);
        reg_read(mmc_pkg::ADDR_CTRL1, 8'h81);
        reg_write(mmc_pkg::ADDR_CTRL1, 8'h00);
        repeat (200) @(negedge clk);
        reg_read(mmc_pkg::ADDR_OPSTATE, 8'h00);
        stop_test;
    end

endmodule : mmc_meas_ctrl_tb_top

`default_nettype wire
